// *** inc/pcis_pkg.sv ***
// Contract
// R1: Channel clock edge resets PWM latch; comparator trip sets it again.
// R2: Reference is a 12-bit setting from resistors, memory or host.
// R3: Range 0 scales output 5.5x reference, range 1 scales 2.75x.
// R4: Positive limit drops top switch; negative limit drops bottom switch at once.
// R5: Repeated peak overcurrent events set the channel overcurrent fault.
// R6: Bottom switch on when top off; in continuous mode until comparator trips.
// R7: In discontinuous mode bottom switch drops on reverse-current comparator.
// R8: Initialization starts on good supplies, restore command or reset command.
// R9: RAM self-test runs during every initialization.
// R10: Failed self-test answers only device address 0x7C and globals 0x5A, 0x5B.
// R11: Failed self-test flags persistent memory fault and skips memory access.
// R12: Failed self-test drives run lines and timebase low continuously.
// R13: A later passing self-test, e.g. after reset command, restores operation.
// R14: During initialization PWM off, run lines and timebase low, fault pins released.
// R15: Initialization reads resistor pins and copies memory into command memory.
// R16: Ignore-pins bit 6 makes memory source everything except the device address.
// R17: Address-select pins supply part of the address unless both are open.
// R18: Initialization takes about 35ms; timebase released after input above threshold.
// R19: Shared run lines held low until every unit ready; timebase released when met.
// R20: Run high and on-delay expired starts monotonic ramp from zero to set point.
// R21: No switching until ramp exceeds rail; rise below 0.25ms skips ramp.
// R22: Output enabled after on-delay; turn-off sequenced by off-delay.
// R23: Timebase is an open-drain bussed clock of nominally 100kHz.
// R24: Device can pull run lines low during reset and restart conditions.
// R25: Delay and rise intervals are counted on shared timebase ticks.
package pcis_pkg;
  localparam int          CLK_HZ         = 50_000_000;
  localparam int          INIT_TIME_US   = 35_000;
  localparam int          INIT_CYCLES    = CLK_HZ / 1_000_000 * INIT_TIME_US;
  localparam int          TB_HZ          = 100_000;
  localparam int          TB_HALF_CYC    = CLK_HZ / TB_HZ / 2;
  localparam int          MIN_RISE_US    = 250;
  localparam int          TB_PERIOD_US   = 1_000_000 / TB_HZ;
  localparam int          MIN_RISE_TICKS = (MIN_RISE_US + TB_PERIOD_US - 1) / TB_PERIOD_US;
  localparam int          DAC_W          = 12;
  localparam int          DLY_W          = 16;
  localparam int          OC_CNT_W       = 4;
  localparam int          CFG_IGNORE_PIN = 6;
  localparam logic [6:0]  ADDR_SAFE      = 7'h7C;
  localparam logic [6:0]  ADDR_GLOBAL_A  = 7'h5A;
  localparam logic [6:0]  ADDR_GLOBAL_B  = 7'h5B;
  localparam logic [1:0]  ADDR_SEL_OPEN  = 2'h3;
  localparam logic [1:0]  RANGE_5X5      = 2'h0;
  localparam logic [DAC_W-1:0] DAC_ZERO  = 12'h000;
  typedef enum logic [2:0] {PCIS_ST_IDLE, PCIS_ST_BIST, PCIS_ST_LOAD, PCIS_ST_WAIT,
                            PCIS_ST_FAIL, PCIS_ST_READY} pcis_init_t;
  typedef enum logic [2:0] {PCIS_CH_OFF, PCIS_CH_ONDLY, PCIS_CH_RAMP, PCIS_CH_ON,
                            PCIS_CH_OFFDLY} pcis_ch_t;
endpackage

// *** src/pcis_sequencer.sv ***
`timescale 1ns/10ps
module pcis_sequencer #(
  parameter int NCH         = 2,
  parameter int INIT_CYC    = pcis_pkg::INIT_CYCLES,
  parameter int OC_REPEAT   = 3
) (
  // Clock and reset
  input  wire logic                            i_clock,
  input  wire logic                            i_rst,
  // Supplies and init triggers
  input  wire logic                            i_supply_3v3_ok,
  input  wire logic                            i_supply_2v5_ok,
  input  wire logic                            i_restore_cmd,
  input  wire logic                            i_reset_cmd,
  input  wire logic                            i_bist_done,
  input  wire logic                            i_bist_pass,
  input  wire logic                            i_input_above_on,
  // Configuration sources
  input  wire logic [15:0]                     i_global_config_word,
  input  wire logic                            i_cfg_pins_open,
  input  wire logic [1:0]                      i_addr_sel_open,
  input  wire logic [6:0]                      i_addr_from_pins,
  input  wire logic [6:0]                      i_addr_from_nvm,
  input  wire logic [NCH*pcis_pkg::DAC_W-1:0]  i_ref_from_pins,
  input  wire logic [NCH*pcis_pkg::DAC_W-1:0]  i_ref_from_nvm,
  input  wire logic [NCH*pcis_pkg::DAC_W-1:0]  i_ref_from_host,
  input  wire logic [NCH-1:0]                  i_ref_host_valid,
  input  wire logic [NCH*2-1:0]                i_out_range,
  input  wire logic [NCH*pcis_pkg::DLY_W-1:0]  i_on_delay,
  input  wire logic [NCH*pcis_pkg::DLY_W-1:0]  i_off_delay,
  input  wire logic [NCH*pcis_pkg::DLY_W-1:0]  i_rise_time,
  // Serial address check
  input  wire logic [6:0]                      i_serial_addr,
  // Pins and per-cycle comparators
  input  wire logic [NCH-1:0]                  i_run_line,
  input  wire logic                            i_timebase_in,
  input  wire logic [NCH-1:0]                  i_chan_clock,
  input  wire logic [NCH-1:0]                  i_pwm_comparator,
  input  wire logic [NCH-1:0]                  i_peak_limit_pos,
  input  wire logic [NCH-1:0]                  i_peak_limit_neg,
  input  wire logic [NCH-1:0]                  i_reverse_current_comparator,
  input  wire logic [NCH-1:0]                  i_discontinuous_conduction,
  input  wire logic [NCH-1:0]                  i_ramp_above_rail,
  input  wire logic [NCH-1:0]                  i_fault_clear,
  // Outputs
  output logic [NCH-1:0]                       o_run_line_oe,
  output logic                                 o_timebase_oe,
  output logic [NCH-1:0]                       o_fault_share_pin_oe,
  output logic [NCH-1:0]                       o_top_on,
  output logic [NCH-1:0]                       o_bottom_on,
  output logic [NCH-1:0]                       o_overcurrent_fault,
  output logic [NCH*pcis_pkg::DAC_W-1:0]       o_ref_cmd,
  output logic [NCH*2-1:0]                     o_gain_range,
  output logic                                 o_addr_accept,
  output logic [6:0]                           o_device_addr,
  output logic                                 o_memory_fault,
  output logic                                 o_nvm_read,
  output logic                                 o_init_busy,
  output logic                                 o_seq_ready
);
  import pcis_pkg::*;

  // Three-stage pin synchronisers
  logic [NCH:0] sync1;
  logic [NCH:0] sync2;
  logic [NCH:0] sync3;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= {i_timebase_in, i_run_line};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end
  logic [NCH:0] pin_q;
  logic [NCH:0] next_pin_q;
  always_comb begin
    for (int k = 0; k <= NCH; k++) begin
      next_pin_q[k] = (sync2[k] == sync3[k]) ? sync2[k] : pin_q[k];
    end
  end
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) pin_q <= '0;
    else pin_q <= next_pin_q;
  end

  // Init sequencer state
  pcis_init_t st;
  pcis_init_t next_st;
  logic [31:0] icnt;
  logic [31:0] next_icnt;
  logic        mem_fault;
  logic        next_mem_fault;
  logic [6:0]  dev_addr;
  logic [6:0]  next_dev_addr;
  logic        supplies_ok;
  logic        restart;
  assign supplies_ok = i_supply_3v3_ok & i_supply_2v5_ok;
  assign restart     = i_restore_cmd | i_reset_cmd;

  always_comb begin
    next_st        = st;
    next_icnt      = icnt;
    next_mem_fault = mem_fault;
    next_dev_addr  = dev_addr;
    if (!supplies_ok) begin
      next_st = PCIS_ST_IDLE;
    // R8: restart commands
    end else if (restart) begin
      next_st   = PCIS_ST_BIST;
      next_icnt = '0;
    end else begin
      case (st)
        PCIS_ST_IDLE: begin
          // R8: supplies start init
          next_st   = PCIS_ST_BIST;
          next_icnt = '0;
        end
        PCIS_ST_BIST: begin
          next_icnt = icnt + 32'h1;
          // R9: RAM self-test
          if (i_bist_done) begin
            // R11: persistent memory fault
            next_mem_fault = !i_bist_pass;
            // R13: pass restores operation
            next_st = i_bist_pass ? PCIS_ST_LOAD : PCIS_ST_FAIL;
          end
        end
        PCIS_ST_LOAD: begin
          next_icnt = icnt + 32'h1;
          // R17: low four address bits from pins unless both open
          if (i_addr_sel_open == ADDR_SEL_OPEN) next_dev_addr = i_addr_from_nvm;
          else next_dev_addr = {i_addr_from_nvm[6:4], i_addr_from_pins[3:0]};
          // R18: about 35ms init
          if (icnt >= INIT_CYC - 1) next_st = PCIS_ST_WAIT;
        end
        PCIS_ST_WAIT: begin
          // R18: wait input above threshold
          if (i_input_above_on) next_st = PCIS_ST_READY;
        end
        PCIS_ST_FAIL: next_st = PCIS_ST_FAIL;
        PCIS_ST_READY: if (!i_input_above_on) next_st = PCIS_ST_WAIT;
        default: next_st = PCIS_ST_IDLE;
      endcase
    end
  end
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      st        <= PCIS_ST_IDLE;
      icnt      <= '0;
      mem_fault <= 1'b0;
      dev_addr  <= ADDR_SAFE;
    end else begin
      st        <= next_st;
      icnt      <= next_icnt;
      mem_fault <= next_mem_fault;
      dev_addr  <= next_dev_addr;
    end
  end

  logic in_init;
  logic ready;
  assign in_init = (st != PCIS_ST_READY) && (st != PCIS_ST_WAIT);
  assign ready   = (st == PCIS_ST_READY);

  // R10: address filter on failure
  always_comb begin
    if (st == PCIS_ST_FAIL) begin
      o_addr_accept = (i_serial_addr == ADDR_SAFE) || (i_serial_addr == ADDR_GLOBAL_A) ||
                      (i_serial_addr == ADDR_GLOBAL_B);
    end else begin
      o_addr_accept = ready && (i_serial_addr == dev_addr);
    end
  end

  // R23: open-drain 100kHz timebase
  logic [15:0] tb_div;
  logic [15:0] next_tb_div;
  logic        tb_low;
  logic        next_tb_low;
  logic        tb_prev;
  logic        tb_tick;
  always_comb begin
    next_tb_div = tb_div + 16'h1;
    next_tb_low = tb_low;
    if (tb_div >= 16'(TB_HALF_CYC - 1)) begin
      next_tb_div = '0;
      next_tb_low = !tb_low;
    end
  end
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      tb_div  <= '0;
      tb_low  <= 1'b0;
      tb_prev <= 1'b0;
    end else begin
      tb_div  <= next_tb_div;
      tb_low  <= next_tb_low;
      tb_prev <= pin_q[NCH];
    end
  end
  // R25: tick on shared line rise
  assign tb_tick = pin_q[NCH] & !tb_prev;

  // R12: fail holds low; R14: init holds low; R19: released when met
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_timebase_oe        <= 1'b1;
      o_run_line_oe        <= '1;
      o_fault_share_pin_oe <= '0;
      o_memory_fault       <= 1'b0;
      o_nvm_read           <= 1'b0;
      o_device_addr        <= ADDR_SAFE;
      o_init_busy          <= 1'b1;
      o_seq_ready          <= 1'b0;
    end else begin
      o_timebase_oe        <= !ready | tb_low;
      // R24: pull run lines in reset
      o_run_line_oe        <= {NCH{!ready}};
      // R14: fault pins released
      o_fault_share_pin_oe <= '0;
      o_memory_fault       <= next_mem_fault;
      // R11: no memory access on fail; R15: copy memory
      o_nvm_read           <= (next_st == PCIS_ST_LOAD);
      o_device_addr        <= dev_addr;
      o_init_busy          <= in_init;
      o_seq_ready          <= ready;
    end
  end

  logic ignore_pins;
  // R16: ignore-pins bit
  assign ignore_pins = i_global_config_word[CFG_IGNORE_PIN] | i_cfg_pins_open;

  // Per-channel logic
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic [DAC_W-1:0] set_pt;
    logic [DAC_W-1:0] ramp;
    logic [DAC_W-1:0] next_ramp;
    logic [DLY_W-1:0] dcnt;
    logic [DLY_W-1:0] next_dcnt;
    logic [DLY_W-1:0] on_d;
    logic [DLY_W-1:0] off_d;
    logic [DLY_W-1:0] rise;
    pcis_ch_t         cs;
    pcis_ch_t         next_cs;
    logic             latch;
    logic             next_latch;
    logic             bot;
    logic             next_bot;
    logic [OC_CNT_W-1:0] occ;
    logic [OC_CNT_W-1:0] next_occ;
    logic             ocf;
    logic             next_ocf;
    logic             sw_en;
    logic             run_hi;

    assign on_d   = i_on_delay[c*DLY_W +: DLY_W];
    assign off_d  = i_off_delay[c*DLY_W +: DLY_W];
    assign rise   = i_rise_time[c*DLY_W +: DLY_W];
    assign run_hi = pin_q[c] & ready;

    // R2: reference source select
    always_comb begin
      if (i_ref_host_valid[c]) set_pt = i_ref_from_host[c*DAC_W +: DAC_W];
      else if (ignore_pins) set_pt = i_ref_from_nvm[c*DAC_W +: DAC_W];
      else set_pt = i_ref_from_pins[c*DAC_W +: DAC_W];
    end

    // R20: ramp sequencing; R22: on and off delays
    always_comb begin
      next_cs   = cs;
      next_dcnt = dcnt;
      next_ramp = ramp;
      case (cs)
        PCIS_CH_OFF: begin
          next_ramp = DAC_ZERO;
          next_dcnt = '0;
          if (run_hi) next_cs = PCIS_CH_ONDLY;
        end
        PCIS_CH_ONDLY: begin
          if (!run_hi) next_cs = PCIS_CH_OFF;
          else if (dcnt >= on_d) begin
            next_dcnt = '0;
            // R21: short rise skips ramp
            if (rise < DLY_W'(MIN_RISE_TICKS)) begin
              next_ramp = set_pt;
              next_cs   = PCIS_CH_ON;
            end else next_cs = PCIS_CH_RAMP;
          end else if (tb_tick) next_dcnt = dcnt + 1'b1;
        end
        PCIS_CH_RAMP: begin
          if (!run_hi) begin
            next_cs   = PCIS_CH_OFFDLY;
            next_dcnt = '0;
          end else if (tb_tick) begin
            next_dcnt = dcnt + 1'b1;
            next_ramp = DAC_W'(({4'h0, set_pt} * 28'(dcnt + 1'b1)) / 28'(rise));
            if (dcnt + 1'b1 >= rise) begin
              next_ramp = set_pt;
              next_cs   = PCIS_CH_ON;
            end
          end
        end
        PCIS_CH_ON: begin
          next_ramp = set_pt;
          if (!run_hi) begin
            next_cs   = PCIS_CH_OFFDLY;
            next_dcnt = '0;
          end
        end
        PCIS_CH_OFFDLY: begin
          if (!ready) next_cs = PCIS_CH_OFF;
          else if (dcnt >= off_d) next_cs = PCIS_CH_OFF;
          else if (tb_tick) next_dcnt = dcnt + 1'b1;
        end
        default: next_cs = PCIS_CH_OFF;
      endcase
    end

    // R21: wait for ramp above rail; R14: PWM off in init
    assign sw_en = ((cs == PCIS_CH_RAMP) && i_ramp_above_rail[c]) ||
                   (cs == PCIS_CH_ON) || (cs == PCIS_CH_OFFDLY);

    // R1: PWM latch; R4, R6, R7 bottom switch
    always_comb begin
      next_latch = latch;
      next_bot   = bot;
      if (i_chan_clock[c]) begin
        next_latch = 1'b0;
        next_bot   = 1'b1;
      end else if (i_pwm_comparator[c]) begin
        next_latch = 1'b1;
        next_bot   = 1'b0;
      end
      // R4: positive limit
      if (i_peak_limit_pos[c]) next_latch = 1'b0;
      // R4: negative limit; R7: zero current
      if (i_peak_limit_neg[c] ||
          (i_discontinuous_conduction[c] && i_reverse_current_comparator[c])) begin
        next_bot = 1'b0;
      end
      if (!sw_en) begin
        next_latch = 1'b0;
        next_bot   = 1'b0;
      end
    end

    // R5: repeated overcurrent fault
    always_comb begin
      next_occ = occ;
      next_ocf = ocf & !i_fault_clear[c];
      if (i_peak_limit_pos[c] && !latch) begin
        next_occ = '0;
      end else if (i_peak_limit_pos[c]) begin
        next_occ = occ + 1'b1;
        if (occ + 1'b1 >= OC_CNT_W'(OC_REPEAT)) next_ocf = 1'b1;
      end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
        cs    <= PCIS_CH_OFF;
        dcnt  <= '0;
        ramp  <= DAC_ZERO;
        latch <= 1'b0;
        bot   <= 1'b0;
        occ   <= '0;
        ocf   <= 1'b0;
      end else begin
        cs    <= next_cs;
        dcnt  <= next_dcnt;
        ramp  <= next_ramp;
        latch <= next_latch;
        bot   <= next_bot;
        occ   <= next_occ;
        ocf   <= next_ocf;
      end
    end

    assign o_top_on[c]                   = latch;
    assign o_bottom_on[c]                = bot;
    assign o_overcurrent_fault[c]        = ocf;
    assign o_ref_cmd[c*DAC_W +: DAC_W]   = ramp;
    // R3: output range select
    assign o_gain_range[c*2 +: 2]        = i_out_range[c*2 +: 2];
  end
endmodule

// *** test/pcis_sva.sv ***
`timescale 1ns/10ps
module pcis_sva #(
  parameter int NCH = 2
) (
  // Clock, reset and commands
  input wire logic             i_clock,
  input wire logic             i_rst,
  input wire logic             i_restore_cmd,
  input wire logic             i_reset_cmd,
  input wire logic             i_input_above_on,
  input wire logic [6:0]       i_serial_addr,
  input wire logic [NCH*2-1:0] i_out_range,
  // Per-cycle comparators
  input wire logic [NCH-1:0]   i_chan_clock,
  input wire logic [NCH-1:0]   i_pwm_comparator,
  input wire logic [NCH-1:0]   i_peak_limit_pos,
  input wire logic [NCH-1:0]   i_peak_limit_neg,
  input wire logic [NCH-1:0]   i_reverse_current_comparator,
  input wire logic [NCH-1:0]   i_discontinuous_conduction,
  // Watched outputs
  input wire logic [NCH-1:0]   o_run_line_oe,
  input wire logic             o_timebase_oe,
  input wire logic [NCH-1:0]   o_fault_share_pin_oe,
  input wire logic [NCH-1:0]   o_top_on,
  input wire logic [NCH-1:0]   o_bottom_on,
  input wire logic [NCH-1:0]   o_overcurrent_fault,
  input wire logic [NCH*2-1:0] o_gain_range,
  input wire logic             o_addr_accept,
  input wire logic             o_memory_fault,
  input wire logic             o_nvm_read,
  input wire logic             o_init_busy,
  input wire logic             o_seq_ready
);
  // Single domain, reset disables all
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  // Pin and sequencing holds
  fault_float_a: assert property (o_fault_share_pin_oe == '0)
    else $error("fault pin driven");
  init_hold_a: assert property (o_init_busy |-> &o_run_line_oe && o_timebase_oe)
    else $error("lines free during init");
  fail_hold_a: assert property (o_memory_fault |-> &o_run_line_oe && o_timebase_oe && !o_nvm_read)
    else $error("fail state lines free");
  fail_addr_a: assert property (o_memory_fault && !$past(i_reset_cmd) && !$past(i_restore_cmd)
    |-> o_addr_accept == (i_serial_addr inside {7'h7C, 7'h5A, 7'h5B}))
    else $error("fail address accept wrong");
  ready_free_a: assert property (o_seq_ready |-> !(|o_run_line_oe) && !o_init_busy)
    else $error("ready with lines held");
  vin_gate_a: assert property ($rose(o_seq_ready)
    |-> $past(i_input_above_on) || $past(i_input_above_on, 2))
    else $error("ready without input");
  load_len_a: assert property ($rose(o_nvm_read) |-> o_nvm_read[*8])
    else $error("memory copy cut short");
  // Switch commands, channel 0; gain range, all channels
  top_clr_a: assert property (i_chan_clock[0] && !i_pwm_comparator[0] |=> !o_top_on[0])
    else $error("clock left top on");
  pos_lim_a: assert property (i_peak_limit_pos[0] |=> !o_top_on[0])
    else $error("top on past limit");
  neg_lim_a: assert property (i_peak_limit_neg[0] && !i_chan_clock[0] |=> !o_bottom_on[0])
    else $error("bottom on past limit");
  dcm_off_a: assert property (i_discontinuous_conduction[0] && i_reverse_current_comparator[0]
    && !i_chan_clock[0] |=> !o_bottom_on[0])
    else $error("bottom on at zero current");
  gain_a: assert property (o_gain_range == i_out_range)
    else $error("range mismatch");

  // Main scenarios reached
  ready_c: cover property ($rose(o_seq_ready));
  fail_c: cover property ($rose(o_memory_fault));
  oc_c: cover property ($rose(o_overcurrent_fault[0]));
endmodule

bind pcis_sequencer pcis_sva #(.NCH(NCH)) pcis_sva_i (.i_clock, .i_rst, .i_restore_cmd,
  .i_reset_cmd, .i_input_above_on, .i_serial_addr, .i_out_range, .i_chan_clock,
  .i_pwm_comparator, .i_peak_limit_pos, .i_peak_limit_neg, .i_reverse_current_comparator,
  .i_discontinuous_conduction, .o_run_line_oe, .o_timebase_oe, .o_fault_share_pin_oe,
  .o_top_on, .o_bottom_on, .o_overcurrent_fault, .o_gain_range, .o_addr_accept,
  .o_memory_fault, .o_nvm_read, .o_init_busy, .o_seq_ready);

// *** test/pcis_od_bus.sv ***
`timescale 1ns/10ps
module pcis_od_bus (
  // Device pulls
  input  wire logic [1:0] i_run_oe,
  input  wire logic       i_tb_oe,
  // Other unit pulls
  input  wire logic [1:0] i_ext_run_low,
  // Resolved wires
  output logic [1:0]      o_run,
  output logic            o_tb
);
  // other unit holds shared run low
  assign o_run = ~(i_run_oe | i_ext_run_low);
  assign o_tb = ~i_tb_oe;
endmodule

// *** test/tb.sv ***
`timescale 1ns/10ps
module tb;
  import pcis_pkg::*;
  logic i_clock = 0, i_rst = 1, i_supply_3v3_ok = 0, i_supply_2v5_ok = 0;
  logic i_restore_cmd = 0, i_reset_cmd = 0, i_bist_done = 0, i_bist_pass = 1;
  logic i_input_above_on = 0, i_cfg_pins_open = 0, i_timebase_in;
  logic [15:0] i_global_config_word = 16'h0040;
  logic [1:0] i_addr_sel_open = 2'h0, i_ref_host_valid = 2'h1, i_run_line, ext = 2'h3;
  logic [6:0] i_addr_from_pins = 7'h05, i_addr_from_nvm = 7'h28, i_serial_addr = 7'h00;
  logic [23:0] i_ref_from_pins = 24'h111222, i_ref_from_nvm = 24'h2C0333;
  logic [23:0] i_ref_from_host = 24'h0003A5;
  logic [3:0] i_out_range = 4'h4;
  logic [31:0] i_on_delay = 32'h00030002, i_off_delay = 32'h00010003;
  logic [31:0] i_rise_time = 32'h001E0000;
  logic [1:0] i_chan_clock = 0, i_pwm_comparator = 0, i_peak_limit_pos = 0;
  logic [1:0] i_peak_limit_neg = 0, i_reverse_current_comparator = 0;
  logic [1:0] i_discontinuous_conduction = 0, i_ramp_above_rail = 2'h3, i_fault_clear = 0;
  logic [1:0] o_run_line_oe, o_fault_share_pin_oe, o_top_on, o_bottom_on;
  logic [1:0] o_overcurrent_fault, o_gain_range;
  logic [23:0] o_ref_cmd;
  logic [6:0] o_device_addr;
  logic o_timebase_oe, o_addr_accept, o_memory_fault, o_nvm_read, o_init_busy, o_seq_ready;
  int miscompares = 0, total_checks = 0, cycles = 0, n;

  pcis_sequencer #(.INIT_CYC(20)) pcis_sequencer_i (.*);
  pcis_od_bus pcis_od_bus_i (.i_run_oe(o_run_line_oe), .i_tb_oe(o_timebase_oe),
    .i_ext_run_low(ext), .o_run(i_run_line), .o_tb(i_timebase_in));

  // Clock and run ceiling
  always #10 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      $display("CHECK FAILED %0t timeout", $time);
      results();
    end
  end

  task automatic chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask

  task automatic tick;
    @(posedge i_clock);
    #1;
  endtask

  // One-cycle pulse on channel 0 of a chosen input
  task automatic pulse(input int k);
    @(posedge i_clock);
    case (k)
      0: i_chan_clock <= 2'h1;
      1: i_pwm_comparator <= 2'h1;
      2: i_peak_limit_pos <= 2'h1;
      3: i_peak_limit_neg <= 2'h1;
      4: i_reverse_current_comparator <= 2'h1;
      default: i_fault_clear <= 2'h1;
    endcase
    @(posedge i_clock);
    {i_chan_clock, i_pwm_comparator, i_peak_limit_pos} <= 6'h00;
    {i_peak_limit_neg, i_reverse_current_comparator, i_fault_clear} <= 6'h00;
    #1;
  endtask

  task automatic t_init;
    @(posedge i_clock);
    {i_supply_3v3_ok, i_supply_2v5_ok} <= 2'h3;
    repeat (3) tick;
    chk(o_init_busy === 1'b1 && &o_run_line_oe === 1'b1 && o_top_on === 2'h0, "init hold");
    @(posedge i_clock);
    i_bist_done <= 1'b1;
    for (n = 0; n < 20 && o_nvm_read !== 1'b1; n++) tick;
    chk(o_nvm_read === 1'b1, "no memory copy");
    repeat (40) tick;
    chk(o_seq_ready === 1'b0 && o_timebase_oe === 1'b1, "timebase freed early");
    @(posedge i_clock);
    i_input_above_on <= 1'b1;
    i_serial_addr <= 7'h25;
    for (n = 0; n < 10 && o_seq_ready !== 1'b1; n++) tick;
    chk(o_seq_ready === 1'b1 && o_run_line_oe === 2'h0, "run not freed");
    chk(o_device_addr === 7'h25 && o_addr_accept === 1'b1, "address split");
  endtask

  task automatic t_start;
    logic [11:0] prev, first0;
    int steps;
    logic mono;
    logic pre;
    prev = 0;
    first0 = 0;
    steps = 0;
    mono = 1;
    pre = 0;
    @(posedge i_clock);
    ext <= 2'h0;
    i_ramp_above_rail <= 2'h1;
    i_pwm_comparator <= 2'h2;
    repeat (300) tick;
    chk(o_ref_cmd[11:0] === 12'h000, "on delay skipped");
    for (n = 0; n < 20000 && o_ref_cmd[23:12] !== 12'h2C0; n++) begin
      tick;
      if (first0 === 12'h000) first0 = o_ref_cmd[11:0];
      if (o_ref_cmd[23:12] < prev) mono = 0;
      if (o_ref_cmd[23:12] != prev) steps++;
      prev = o_ref_cmd[23:12];
      if (o_top_on[1] !== 1'b0) pre = 1;
    end
    chk(o_ref_cmd === 24'h2C03A5, "set points");
    chk(first0 === 12'h3A5, "short rise ramped");
    chk(mono === 1'b1 && steps > 2, "ramp shape");
    chk(pre === 1'b0, "switched below rail");
    tick;
    chk(o_top_on[1] === 1'b1, "no switching once on");
    @(posedge i_clock);
    i_pwm_comparator <= 2'h0;
    i_ramp_above_rail <= 2'h3;
    i_global_config_word <= 16'h0000;
    repeat (2) tick;
    chk(o_ref_cmd[23:12] === 12'h111, "pin set point unused");
    @(posedge i_clock);
    i_cfg_pins_open <= 1'b1;
    repeat (2) tick;
    chk(o_ref_cmd[23:12] === 12'h2C0, "open pins not ignored");
  endtask

  task automatic t_pwm;
    pulse(1);
    chk(o_top_on[0] === 1'b1 && o_bottom_on[0] === 1'b0, "comparator set");
    pulse(0);
    chk(o_top_on[0] === 1'b0 && o_bottom_on[0] === 1'b1, "clock reset");
    @(posedge i_clock);
    i_discontinuous_conduction <= 2'h1;
    pulse(4);
    chk(o_bottom_on[0] === 1'b0, "reverse current");
    @(posedge i_clock);
    i_discontinuous_conduction <= 2'h0;
    pulse(0);
    pulse(3);
    chk(o_bottom_on[0] === 1'b0, "negative limit");
    repeat (3) begin
      pulse(1);
      pulse(2);
      chk(o_top_on[0] === 1'b0, "positive limit");
    end
    chk(o_overcurrent_fault[0] === 1'b1, "no overcurrent fault");
    pulse(5);
    chk(o_overcurrent_fault[0] === 1'b0, "fault not cleared");
    @(posedge i_clock);
    ext <= 2'h1;
    repeat (300) tick;
    chk(o_ref_cmd[11:0] === 12'h3A5, "off delay skipped");
    repeat (2000) tick;
    chk(o_ref_cmd[11:0] === 12'h000 && o_top_on[0] === 1'b0, "no turn-off");
  endtask

  task automatic t_fail;
    @(posedge i_clock);
    i_bist_pass <= 1'b0;
    pulse(5);
    @(posedge i_clock);
    i_restore_cmd <= 1'b1;
    @(posedge i_clock);
    i_restore_cmd <= 1'b0;
    for (n = 0; n < 20 && o_memory_fault !== 1'b1; n++) tick;
    chk(o_memory_fault === 1'b1 && o_nvm_read === 1'b0, "no memory fault");
    repeat (300) tick;
    chk(&o_run_line_oe === 1'b1 && o_timebase_oe === 1'b1, "lines freed");
    for (int a = 0; a < 4; a++) begin
      @(posedge i_clock);
      i_serial_addr <= (a == 0) ? 7'h7C : (a == 1) ? 7'h5A : (a == 2) ? 7'h5B : 7'h25;
      tick;
      chk(o_addr_accept === (a < 3), "fail address");
    end
    @(posedge i_clock);
    i_bist_pass <= 1'b1;
    i_reset_cmd <= 1'b1;
    @(posedge i_clock);
    i_reset_cmd <= 1'b0;
    for (n = 0; n < 80 && o_seq_ready !== 1'b1; n++) tick;
    chk(o_seq_ready === 1'b1 && o_memory_fault === 1'b0, "no recovery");
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge i_clock);
    i_rst <= 1'b0;
    t_init;
    t_start;
    t_pwm;
    t_fail;
    results();
  end
endmodule
